// file: rtl/watchdog_and_reset_control.v
`timescale 1ns/100ps
`include "wdt_reset_defs.vh"

module watchdog_and_reset_control #(
    parameter POR_DELAY_CYCLES = (`CLK_SYS_HZ / 1000) * `POWER_ON_DELAY_MS,
    parameter LOW_SUPPLY_QUAL_CYCLES = 2000,
    parameter WD_WIDTH = 19
) (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire power_on_n_i,
    input wire slow_internal_rc_osc_i,
    input wire low_supply_i,
    input wire power_down_flag_i,
    input wire clear_watchdog_instruction_i,
    input wire halt_instruction_i,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output reg device_reset_o,
    output reg pc_sp_reset_o,
    output reg timeout_status_flag_o,
    output reg port_preset_o
);

    // ==========================================================
    // Overview
    // All logic runs on the system clock. The slow oscillator only
    // supplies edge events. Reset requests are outputs; this block
    // does not reset itself from them, only from the reset input and
    // the power-on indication, save that a level-code fault reloads the
    // level register and a watchdog key fault clears the watchdog count,
    // so cause flags survive the resets
    // they describe. Software reaches the registers at 0x00 control,
    // 0x04 cause flags, 0x08 reset key, 0x0c level code and 0x10
    // status, one register per word in bits 7:0.

    // ==========================================================
    // Helpers
    // Bit of the watchdog count that marks a timeout for each select
    // code; the jumps are uneven, two bits apart below code 4 and one
    // bit apart above it, so a table is clearer than arithmetic
    function [4:0] tap_index;
        input [2:0] sel;
        begin
            case (sel)
                3'd0: tap_index = 5'd8;
                3'd1: tap_index = 5'd10;
                3'd2: tap_index = 5'd12;
                3'd3: tap_index = 5'd14;
                3'd4: tap_index = 5'd15;
                3'd5: tap_index = 5'd16;
                3'd6: tap_index = 5'd17;
                default: tap_index = 5'd18;
            endcase
        end
    endfunction

    // True only for the four legal level codes; every other pattern,
    // including all zeros and all ones, is treated as a corrupted
    // register and leads to a level-code reset
    function level_code_ok;
        input [7:0] code;
        begin
            level_code_ok = (code == `LEVEL_CODE_2V10) || (code == `LEVEL_CODE_2V55) ||
                (code == `LEVEL_CODE_3V15) || (code == `LEVEL_CODE_3V80);
        end
    endfunction

    // ==========================================================
    // Power-on state and input sync
    // The slow oscillator and the supply monitor are asynchronous to
    // the system clock. Each passes three flops; a new level is only
    // accepted once stages two and three agree, which filters a single
    // metastable sample. The slow clock is then used as an edge event
    // in the system domain, never as a clock of its own, so the whole
    // block stays on one clock and needs no domain crossing logic.
    reg [31:0] por_count;
    reg por_busy;
    reg [2:0] slow_sync;
    reg [2:0] low_sync;
    reg slow_level;
    reg low_level;
    wire slow_rise = slow_sync[1] & slow_sync[2] & ~slow_level;

    // Three-stage synchronisers, change counted when stages 2 and 3 agree
    always @(posedge clk_sys_i) begin
        slow_sync <= {slow_sync[1:0], slow_internal_rc_osc_i};
        low_sync <= {low_sync[1:0], low_supply_i};
        // Sync stages are not reset; they flush within three clocks
        if (!reset_n_i) begin
            slow_level <= 1'b0;
            low_level <= 1'b0;
        end else begin
            if (slow_sync[1] == slow_sync[2])
                slow_level <= slow_sync[2];
            if (low_sync[1] == low_sync[2])
                low_level <= low_sync[2];
        end
    end

    // ==========================================================
    // Registers and fault state
    // The three keyed registers hold redundant patterns so that a
    // flipped bit is noticed (in the watchdog control only in its key
    // field, bits 7:3): any value off the legal list starts a
    // fault timer that ends in a reset request. The cause flags keep
    // only bits 3:0; the upper bits of the word read as zero.
    // Fault timers count slow clock edges with the bad value held.
    reg [7:0] watchdog_control;
    reg [7:0] reset_key_register;
    reg [7:0] low_supply_level_register;
    reg [3:0] reset_cause_flags;
    // Watchdog count and fault timers
    reg [WD_WIDTH-1:0] wd_count;
    reg wd_tap_prev;
    reg [1:0] wd_key_fault_cnt;
    reg [1:0] key_reg_fault_cnt;
    reg [1:0] level_fault_cnt;
    // Supply filter and reset stretch
    reg [31:0] low_qual_cnt;
    reg [7:0] pulse_cnt;

    // Bus address phase capture
    // AHB-Lite slave with no wait states: the address phase is
    // captured on the edge where it is accepted, and the data phase
    // follows in the next cycle. Writes use hwdata in that data phase;
    // reads are driven from the captured address. Transfer size is
    // not decoded, every register is one aligned word.
    reg wr_pend;
    reg rd_pend;
    reg [7:0] addr_q;
    wire bus_go = hsel & hready & htrans[1];

    // Decoded fields and fault conditions
    // A key fault fires on the second slow edge with the bad value
    // still in place, which lands between one and two slow periods
    // after the bad write, depending on its phase.
    wire [4:0] watchdog_key_field = watchdog_control[`WDC_KEY_MSB:`WDC_KEY_LSB];
    wire [2:0] timeout_select = watchdog_control[`WDC_SEL_MSB:`WDC_SEL_LSB];
    wire wd_key_bad = (watchdog_key_field != `WD_KEY_A) && (watchdog_key_field != `WD_KEY_B);
    wire key_reg_bad = (reset_key_register != `RESET_KEY_A) && (reset_key_register != `RESET_KEY_B);
    wire level_bad = !level_code_ok(low_supply_level_register);
    wire wd_tap = wd_count[tap_index(timeout_select)];
    wire wd_overflow = slow_rise & wd_tap & ~wd_tap_prev;
    wire fire_wd_key = slow_rise && wd_key_fault_cnt == 2'd`KEY_FAULT_SLOW_CYCLES - 2'd1 && wd_key_bad;
    wire fire_key_reg = slow_rise && key_reg_fault_cnt == 2'd`KEY_FAULT_SLOW_CYCLES - 2'd1 && key_reg_bad;
    wire fire_level = slow_rise && level_fault_cnt == 2'd`KEY_FAULT_SLOW_CYCLES - 2'd1 && level_bad;
    wire fire_low = !power_down_flag_i && low_qual_cnt == LOW_SUPPLY_QUAL_CYCLES;
    wire sleeping = power_down_flag_i;
    wire fire_any = fire_wd_key | fire_key_reg | fire_level | fire_low |
        (wd_overflow & ~sleeping);
    wire wr_now = wr_pend;

    // Always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Bus phase registers
    // Only one phase is tracked; a new address phase may overlap the
    // data phase of the previous transfer
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend <= bus_go & hwrite;
            rd_pend <= bus_go & ~hwrite;
            if (bus_go)
                addr_q <= haddr[7:0];
        end
    end

    // Read mux; unmapped reads zero
    // Data is only driven during a read data phase; outside it the
    // bus sees zero, so stale register values do not leak onto hrdata
    always @* begin
        hrdata = 32'h0000_0000;
        case (rd_pend ? addr_q : 8'hff)
            `ADDR_WATCHDOG_CONTROL: hrdata = {24'h000000, watchdog_control};
            `ADDR_RESET_CAUSE_FLAGS: hrdata = {28'h0000000, reset_cause_flags};
            `ADDR_RESET_KEY_REGISTER: hrdata = {24'h000000, reset_key_register};
            `ADDR_LOW_SUPPLY_LEVEL: hrdata = {24'h000000, low_supply_level_register};
            `ADDR_CPU_EVENTS: hrdata = {31'h00000000, timeout_status_flag_o};
            default: hrdata = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Power-on delay and port preset
    // The delay restarts on every reset and on every power-on
    // indication. While it runs, the full reset request and the port
    // preset stay high; the counter stops once the delay has ended so
    // it cannot wrap and start a second delay.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i || !power_on_n_i) begin
            por_count <= 32'h0000_0000;
            por_busy <= 1'b1;
        end else if (por_busy) begin
            // Count on until the last delay cycle
            if (por_count == POR_DELAY_CYCLES - 1)
                por_busy <= 1'b0;
            por_count <= por_count + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Control registers
    // A level-code fault puts the level register back to its power-on
    // pattern, so the device comes out of that reset with a legal
    // code. A genuine low supply reset leaves the register alone. The
    // watchdog and reset key registers keep their value.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i || !power_on_n_i) begin
            watchdog_control <= `WATCHDOG_CONTROL_RESET;
            reset_key_register <= `RESET_KEY_RESET;
            low_supply_level_register <= `LOW_SUPPLY_LEVEL_RESET;
        end else if (fire_level) begin
            low_supply_level_register <= `LOW_SUPPLY_LEVEL_RESET;
        end else if (wr_now) begin
            // Unmapped and read-only offsets ignore writes
            case (addr_q)
                `ADDR_WATCHDOG_CONTROL: watchdog_control <= hwdata[7:0];
                `ADDR_RESET_KEY_REGISTER: reset_key_register <= hwdata[7:0];
                `ADDR_LOW_SUPPLY_LEVEL: low_supply_level_register <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Cause flags: set by events, cleared by writing one; set wins
    // Software clears a flag by writing one to it. A fault that fires
    // in the same cycle as the clear wins, because its assignment comes
    // after the clear. Hardware never clears a flag; only reset and
    // power-on return them to zero.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i || !power_on_n_i) begin
            reset_cause_flags <= 4'h0;
        end else begin
            // Write one to clear
            if (wr_now && addr_q == `ADDR_RESET_CAUSE_FLAGS)
                reset_cause_flags <= reset_cause_flags & ~hwdata[3:0];
            if (fire_wd_key)
                reset_cause_flags[`RCF_WDKEY_BIT] <= 1'b1;
            if (fire_level)
                reset_cause_flags[`RCF_LEVEL_BIT] <= 1'b1;
            if (fire_low)
                reset_cause_flags[`RCF_LOWSUP_BIT] <= 1'b1;
            if (fire_key_reg)
                reset_cause_flags[`RCF_KEYREG_BIT] <= 1'b1;
        end
    end

    // ==========================================================
    // Key fault timers, counted in slow clock edges
    // Each timer is held at zero while its register is legal, counts
    // slow edges while it is not, and returns to zero when it fires so
    // that a value left bad fires again two slow periods later.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i || !power_on_n_i) begin
            wd_key_fault_cnt <= 2'd0;
            key_reg_fault_cnt <= 2'd0;
            level_fault_cnt <= 2'd0;
        end else if (slow_rise) begin
            wd_key_fault_cnt <= wd_key_bad && !fire_wd_key ? wd_key_fault_cnt + 2'd1 : 2'd0;
            key_reg_fault_cnt <= key_reg_bad && !fire_key_reg ? key_reg_fault_cnt + 2'd1 : 2'd0;
            level_fault_cnt <= level_bad && !fire_level ? level_fault_cnt + 2'd1 : 2'd0;
        end
    end

    // Low supply qualification filter
    // The filtered supply level must stay low for the full qualifying
    // count before a reset request; shorter dips restart the count.
    // In power down the filter is held clear, so the function is off.
    // The count saturates, keeping the request up while supply is low.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i || !power_on_n_i || !low_level || power_down_flag_i)
            low_qual_cnt <= 32'h0000_0000;
        else if (low_qual_cnt != LOW_SUPPLY_QUAL_CYCLES)
            low_qual_cnt <= low_qual_cnt + 32'h0000_0001;
    end

    // ==========================================================
    // Watchdog counter on slow clock
    // The counter advances once per slow edge. It is cleared by a watchdog key
    // fault, by the clear instruction and by halt. The tap bit chosen
    // by the timeout select is remembered from the previous slow edge
    // so that only its rising edge counts as an overflow. A change of
    // the select code may therefore give one early or late timeout.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i || !power_on_n_i || fire_wd_key || clear_watchdog_instruction_i ||
            halt_instruction_i) begin
            wd_count <= {WD_WIDTH{1'b0}};
            wd_tap_prev <= 1'b0;
        end else if (slow_rise) begin
            wd_count <= wd_count + {{(WD_WIDTH-1){1'b0}}, 1'b1};
            wd_tap_prev <= wd_tap;
        end
    end

    // Timeout flag: set on overflow, cleared by halt or clear instruction
    // Sticky status: only the clear instruction, halt, reset or power
    // on take it down. An overflow in the same cycle as a clear keeps
    // the flag set.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i || !power_on_n_i)
            timeout_status_flag_o <= 1'b0;
        else if (wd_overflow)
            timeout_status_flag_o <= 1'b1;
        else if (clear_watchdog_instruction_i || halt_instruction_i)
            timeout_status_flag_o <= 1'b0;
    end

    // ==========================================================
    // Reset outputs, stretched for a few cycles
    // A fault or normal-mode overflow starts a stretch counter so the request lasts long
    // enough for the core to see it. The full request covers the
    // power-on delay, every fault and a normal-mode overflow; the
    // program counter and stack request covers all of those and also a
    // timeout in sleep or idle. The port preset only follows the
    // power-on delay.
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pulse_cnt <= 8'h00;
            device_reset_o <= 1'b1;
            pc_sp_reset_o <= 1'b1;
            port_preset_o <= 1'b1;
        end else begin
            // Stretch counter reloads on every new event
            if (fire_any)
                pulse_cnt <= 8'h10;
            else if (pulse_cnt != 8'h00)
                pulse_cnt <= pulse_cnt - 8'h01;
            device_reset_o <= por_busy | fire_any | (pulse_cnt != 8'h00);
            pc_sp_reset_o <= por_busy | fire_any | (wd_overflow & sleeping) | (pulse_cnt != 8'h00);
            port_preset_o <= por_busy;
        end
    end

    // ==========================================================
    // Limitations
    // The timeout and fault times are counted in slow edges seen
    // through the synchroniser, so each may be late by a few system
    // clocks. The low supply input is taken as already compared to
    // the selected level; the threshold itself is analog and outside
    // this block. The level code only feeds that comparison and the
    // fault check here.

endmodule // watchdog_and_reset_control

// file: inc/wdt_reset_defs.vh
`ifndef WDT_RESET_DEFS_VH
`define WDT_RESET_DEFS_VH

// ==========================================================
// Register byte addresses
`define ADDR_WATCHDOG_CONTROL 8'h00
`define ADDR_RESET_CAUSE_FLAGS 8'h04
`define ADDR_RESET_KEY_REGISTER 8'h08
`define ADDR_LOW_SUPPLY_LEVEL 8'h0c
`define ADDR_CPU_EVENTS 8'h10

// ==========================================================
// Field positions
`define WDC_KEY_MSB 7
`define WDC_KEY_LSB 3
`define WDC_SEL_MSB 2
`define WDC_SEL_LSB 0
`define RCF_WDKEY_BIT 0
`define RCF_LEVEL_BIT 1
`define RCF_LOWSUP_BIT 2
`define RCF_KEYREG_BIT 3
`define EVT_CLEAR_WDT_BIT 0
`define EVT_HALT_BIT 1

// ==========================================================
// Reset values and valid keys
`define WATCHDOG_CONTROL_RESET 8'h53
`define RESET_KEY_RESET 8'h55
`define LOW_SUPPLY_LEVEL_RESET 8'h55
`define WD_KEY_A 5'h0a
`define WD_KEY_B 5'h15
`define RESET_KEY_A 8'h55
`define RESET_KEY_B 8'haa
`define LEVEL_CODE_2V10 8'h55
`define LEVEL_CODE_2V55 8'h33
`define LEVEL_CODE_3V15 8'h99
`define LEVEL_CODE_3V80 8'haa

// ==========================================================
// Timing
`define CLK_SYS_HZ 200000000
`define POWER_ON_DELAY_MS 50
`define KEY_FAULT_SLOW_CYCLES 2
`define SLOW_CLOCK_HZ 32000

`endif

// file: dv/wdt_reset_checker_asserts.sv
`timescale 1ns/100ps
// ==========================================================
// Checker on the top ports
module wdt_reset_checker #(
    parameter POR_DELAY_CYCLES = 20
) (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire power_on_n_i,
    input wire clear_watchdog_instruction_i,
    input wire halt_instruction_i,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire device_reset_o,
    input wire pc_sp_reset_o,
    input wire timeout_status_flag_o,
    input wire port_preset_o
);
    logic [31:0] since_rel;
    logic rd_cause;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i || !power_on_n_i);
    // Cycles since release, and cause-register data phase
    always @(posedge clk_sys_i) begin
        if (!reset_n_i || !power_on_n_i) begin
            since_rel <= 32'h0;
        end else if (since_rel != 32'hffffffff) begin
            since_rel <= since_rel + 32'h1;
        end
        rd_cause <= hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h04;
    end
    a_reset_holds_out: assert property (disable iff (1'b0) !reset_n_i |=> device_reset_o && port_preset_o)
        else $error("reset outputs low during reset");
    a_por_delay_held: assert property (since_rel < POR_DELAY_CYCLES - 1 |-> device_reset_o && port_preset_o)
        else $error("power-on delay cut short");
    a_full_has_pcsp: assert property (device_reset_o |-> pc_sp_reset_o)
        else $error("full reset without pc/sp reset");
    a_flag_stays_set: assert property (timeout_status_flag_o && !clear_watchdog_instruction_i
        && !halt_instruction_i |=> timeout_status_flag_o)
        else $error("timeout flag dropped by itself");
    a_clear_drops_flag: assert property (clear_watchdog_instruction_i |=> !timeout_status_flag_o)
        else $error("clear left timeout flag set");
    a_halt_drops_flag: assert property (halt_instruction_i |=> !timeout_status_flag_o)
        else $error("halt left timeout flag set");
    a_reset_stretched: assert property ($rose(device_reset_o) |-> device_reset_o [*8])
        else $error("device reset too short");
    a_cause_high_zero: assert property (rd_cause |-> hrdata[31:4] == 28'h0)
        else $error("cause upper bits not zero");
    c_timeout: cover property ($rose(timeout_status_flag_o));
    c_partial: cover property (pc_sp_reset_o && !device_reset_o);
    c_cause_read: cover property (rd_cause);
endmodule // wdt_reset_checker

// file: dv/watchdog_and_reset_control_tb.sv
`timescale 1ns/100ps
module watchdog_and_reset_control_tb;
    logic clk_sys_i, reset_n_i, low_supply_i, power_down_flag_i, clr_i, halt_i, hsel, hwrite, pon_n;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata;
    logic [2:0] sdiv;
    logic [15:0] ok_list [5] = '{16'h00ab, 16'h08aa, 16'h0c33, 16'h0c99, 16'h0caa};
    wire [31:0] hrdata;
    wire hreadyout, device_reset_o, pc_sp_reset_o, timeout_status_flag_o, port_preset_o;
    int failures, num_checks;
    // ==========================================================
    // Clock and slow oscillator, 8 system clocks a period
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) sdiv <= sdiv + 3'h1;
    watchdog_and_reset_control #(.POR_DELAY_CYCLES(20), .LOW_SUPPLY_QUAL_CYCLES(8)) dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .power_on_n_i(pon_n), .slow_internal_rc_osc_i(sdiv[2]),
        .low_supply_i(low_supply_i), .power_down_flag_i(power_down_flag_i), .clear_watchdog_instruction_i(clr_i),
        .halt_instruction_i(halt_i), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .device_reset_o(device_reset_o), .pc_sp_reset_o(pc_sp_reset_o),
        .timeout_status_flag_o(timeout_status_flag_o), .port_preset_o(port_preset_o));
    // ==========================================================
    // Shared tasks
    task report_and_stop;
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            $display("[ERR] %0t bus wait timed out", $time);
            report_and_stop;
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        step;
        htrans <= 2'b00;
        hwdata <= wd;
        step;
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    task wait_out(input int lim, input logic [3:0] mask, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge clk_sys_i);
            if (({port_preset_o, timeout_status_flag_o, pc_sp_reset_o, device_reset_o} & mask) != 4'h0) hit = 1'b1;
        end
    endtask
    task do_reset;
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        chk(port_preset_o, 32'h1);
        repeat (30) @(posedge clk_sys_i);
        chk(device_reset_o, 32'h0);
    endtask
    // ==========================================================
    // Scenarios
    task power_on;
        pon_n <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        pon_n <= 1'b1;
        repeat (30) @(posedge clk_sys_i);
        chk(device_reset_o, 32'h0);
        rdchk(8'h00, 32'h53);
        rdchk(8'h08, 32'h55);
        rdchk(8'h0c, 32'h55);
    endtask
    task fault(input logic [7:0] a, input logic [7:0] bad, input logic [7:0] good, input int b);
        logic hit;
        logic [31:0] r;
        wr(a, {24'h0, bad});
        wait_out(6, 4'h1, hit);
        chk(hit, 32'h0);
        wait_out(40, 4'h1, hit);
        chk(hit, 32'h1);
        rdchk(a, {24'h0, (a == 8'h0c) ? 8'h55 : bad});
        wr(a, {24'h0, good});
        repeat (20) @(posedge clk_sys_i);
        bus(1'b0, 8'h04, 32'h0, r);
        chk(r & (32'hfffffff0 | (32'h1 << b)), 32'h1 << b);
        wr(8'h04, 32'hf);
        rdchk(8'h04, 32'h0);
    endtask
    task low_supply;
        logic hit;
        logic [31:0] r;
        wr(8'h0c, 32'h33);
        low_supply_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        low_supply_i <= 1'b0;
        wait_out(30, 4'h1, hit);
        chk(hit, 32'h0);
        power_down_flag_i <= 1'b1;
        low_supply_i <= 1'b1;
        wait_out(40, 4'h1, hit);
        chk(hit, 32'h0);
        low_supply_i <= 1'b0;
        @(posedge clk_sys_i);
        power_down_flag_i <= 1'b0;
        low_supply_i <= 1'b1;
        wait_out(40, 4'h1, hit);
        chk(hit, 32'h1);
        low_supply_i <= 1'b0;
        bus(1'b0, 8'h04, 32'h0, r);
        chk(r & 32'hfffffff4, 32'h4);
        rdchk(8'h0c, 32'h33);
    endtask
    task wd_over(input logic [2:0] sel, input logic sleep);
        int per;
        logic hit;
        per = 8 << (8 + 2 * sel);
        do_reset;
        power_down_flag_i <= sleep;
        wr(8'h00, {24'h0, 5'b01010, sel});
        for (int k = 0; k < 2; k++) begin
            halt_i <= sleep && k == 0;
            clr_i <= !(sleep && k == 0);
            @(posedge clk_sys_i);
            halt_i <= 1'b0;
            clr_i <= 1'b0;
            wait_out(per * 3 / 4, 4'h7, hit);
            chk(hit, 32'h0);
        end
        wait_out(per / 2, sleep ? 4'h2 : 4'h1, hit);
        chk(hit, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        chk(timeout_status_flag_o, 32'h1);
        chk(device_reset_o, {31'h0, !sleep});
        rdchk(8'h10, 32'h1);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        logic hit;
        {reset_n_i, low_supply_i, power_down_flag_i, clr_i, halt_i, hsel, hwrite} = 7'h0;
        {htrans, haddr, hwdata, sdiv} = '0;
        pon_n = 1'b1;
        do_reset;
        rdchk(8'h00, 32'h53);
        rdchk(8'h08, 32'h55);
        rdchk(8'h0c, 32'h55);
        rdchk(8'h10, 32'h0);
        rdchk(8'h20, 32'h0);
        foreach (ok_list[i]) begin
            wr(ok_list[i][15:8], {24'h0, ok_list[i][7:0]});
            wait_out(40, 4'h1, hit);
            chk(hit, 32'h0);
        end
        power_on;
        fault(8'h00, 8'h03, 8'h53, 0);
        fault(8'h08, 8'h00, 8'haa, 3);
        fault(8'h0c, 8'h12, 8'h55, 1);
        low_supply;
        wd_over(3'h0, 1'b0);
        wd_over(3'h1, 1'b0);
        wd_over(3'h0, 1'b1);
        report_and_stop;
    end
endmodule // watchdog_and_reset_control_tb

bind watchdog_and_reset_control wdt_reset_checker #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) chk_i (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .power_on_n_i(power_on_n_i),
    .clear_watchdog_instruction_i(clear_watchdog_instruction_i), .halt_instruction_i(halt_instruction_i),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .device_reset_o(device_reset_o), .pc_sp_reset_o(pc_sp_reset_o),
    .timeout_status_flag_o(timeout_status_flag_o), .port_preset_o(port_preset_o));
